// ==== sync_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// far end slave: collects what the port shifts out, answers receives
module sync_slave_model #(
	parameter logic [7:0] RX_WORD = 8'h69 // word sent back on receive
) (
	input  wire logic        shift_clock, // clock line level
	input  wire logic        data_line,   // data line level
	input  wire logic        data_oe,     // port drives data line
	output logic             data_drive,  // level while port floats
	output logic [31:0]      bits,        // last bits, newest on top
	output logic [15:0]      count        // bits collected so far
);
	logic [2:0] idx = 3'h0;
	logic       oe_seen = 1'b0;

	initial begin
		data_drive = 1'b0;
		bits = 32'h0;
		count = 16'h0;
	end

	// sample at falling clock edge, lsb arrives first
	always @(negedge shift_clock) begin
		if (data_oe === 1'b1) begin
			bits <= {data_line, bits[31:1]};
			count <= count + 16'h1;
		end
	end

	// a released line shows the inverse of its last level, then the
	// receive word is driven lsb first on each rising clock edge
	always @(posedge shift_clock or negedge data_oe) begin
		if (oe_seen === 1'b1 && data_oe === 1'b0) begin
			data_drive <= ~data_line;
			idx <= 3'h0;
		end else if (data_oe === 1'b0) begin
			data_drive <= RX_WORD[idx];
			idx <= idx + 3'h1;
		end
		oe_seen <= data_oe;
	end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import usart_sync_tx_pkg::*;
	logic                  pclk, presetn, psel, penable, pwrite;
	logic [ADDR_WIDTH-1:0] paddr;
	logic [31:0]           pwdata, prdata, rdata, bits;
	logic                  pready, pslverr, rerr, tx_irq, dt_drive;
	logic                  ck_o, ck_oe, dt_o, dt_oe;
	logic [15:0]           count, c0;
	wire                   ck_line, dt_line;
	int                    err_count, checked, n;
	logic [7:0] ridx [7] = '{IDX_IRQ_FLAGS, IDX_RX_STATUS, IDX_TX_BUFFER,
		IDX_RX_BUFFER, IDX_IRQ_ENABLES, IDX_TX_STATUS, IDX_BAUD_DIV};
	logic [7:0] rexp [7] = '{RST_IRQ_FLAGS, RST_RX_STATUS, RST_TX_BUFFER,
		RST_RX_BUFFER, RST_IRQ_ENABLES, RST_TX_STATUS, RST_BAUD_DIV};

	assign ck_line = ck_oe ? ck_o : 1'b0;
	assign dt_line = dt_oe ? dt_o : dt_drive;

	usart_sync_tx i_usart_sync_tx (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shift_clock_o(ck_o), .shift_clock_oe(ck_oe),
		.serial_data_i(dt_line), .serial_data_o(dt_o),
		.serial_data_oe(dt_oe), .tx_irq(tx_irq));

	sync_slave_model i_sync_slave_model (.shift_clock(ck_line),
		.data_line(dt_line), .data_oe(dt_oe), .data_drive(dt_drive),
		.bits(bits), .count(count));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_idle();
		n = 0;
		do begin
			xfer(1'b0, IDX_TX_STATUS, 8'h0);
			n++;
		end while (rdata[TXS_SHIFTER_EMPTY] !== 1'b1 && n < 300);
		if (n >= 300)
			err_count++;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		conclude();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = '0;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			xfer(1'b0, ridx[i], 8'h0);
			check("reset value", rdata, {24'h0, rexp[i]});
		end
		xfer(1'b0, 8'h00, 8'h0);
		check("unmapped error", {31'h0, rerr}, 32'h1);
		xfer(1'b1, IDX_RX_STATUS, 8'h88);
		xfer(1'b0, IDX_RX_STATUS, 8'h0);
		check("rx status bit3", rdata, 32'h80);
		// divisor first, then mode bits, enable, data
		xfer(1'b1, IDX_BAUD_DIV, 8'h03);
		xfer(1'b1, IDX_TX_STATUS, 8'h98);
		xfer(1'b0, IDX_TX_STATUS, 8'h0);
		check("tx status bit3", rdata, 32'h92);
		check("clock idle", {31'h0, ck_oe}, 32'h0);
		xfer(1'b1, IDX_IRQ_FLAGS, 8'h10);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h0);
		check("flag write", rdata, 32'h0);
		xfer(1'b1, IDX_IRQ_ENABLES, 8'h10);
		xfer(1'b1, IDX_TX_STATUS, 8'hb0);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h0);
		check("flag on enable", rdata, 32'h10);
		check("irq", {31'h0, tx_irq}, 32'h1);
		check("clock drive", {31'h0, ck_oe}, 32'h1);
		xfer(1'b1, IDX_IRQ_ENABLES, 8'h00);
		// the write lands at the closing edge; the request follows later
		repeat (2) @(posedge pclk);
		check("irq masked", {31'h0, tx_irq}, 32'h0);
		c0 = count;
		xfer(1'b1, IDX_TX_BUFFER, 8'ha5);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h0);
		check("pass through", rdata, 32'h10);
		wait_idle();
		check("word8", {8'h0, count - c0, bits[31:24]}, 32'h8a5);
		c0 = count;
		xfer(1'b1, IDX_TX_BUFFER, 8'h3c);
		xfer(1'b1, IDX_TX_BUFFER, 8'hc3);
		xfer(1'b0, IDX_IRQ_FLAGS, 8'h0);
		check("buffer full", rdata, 32'h0);
		wait_idle();
		check("back to back", {count - c0, bits[31:16]}, 32'h10c33c);
		c0 = count;
		xfer(1'b1, IDX_TX_STATUS, 8'hf1);
		xfer(1'b1, IDX_TX_BUFFER, 8'h0f);
		xfer(1'b1, IDX_TX_STATUS, 8'hf0);
		wait_idle();
		check("word9", {count - c0, 7'h0, bits[31:23]}, 32'h9010f);
		xfer(1'b1, IDX_TX_STATUS, 8'hb0);
		xfer(1'b1, IDX_TX_BUFFER, 8'hff);
		repeat (20) @(posedge pclk);
		xfer(1'b1, IDX_TX_STATUS, 8'h90);
		repeat (2) @(posedge pclk);
		check("abort pins", {30'h0, ck_oe, dt_oe}, 32'h0);
		xfer(1'b0, IDX_TX_STATUS, 8'h0);
		check("abort empty", rdata, 32'h92);
		xfer(1'b1, IDX_TX_STATUS, 8'hb0);
		xfer(1'b1, IDX_TX_BUFFER, 8'h55);
		repeat (20) @(posedge pclk);
		xfer(1'b1, IDX_RX_STATUS, 8'ha0);
		repeat (2) @(posedge pclk);
		check("rx pins", {30'h0, ck_oe, dt_oe}, 32'h2);
		n = 0;
		do begin
			xfer(1'b0, IDX_RX_STATUS, 8'h0);
			n++;
		end while (rdata[RCS_SINGLE_RECEIVE_ENABLE] !== 1'b0 && n < 200);
		if (n >= 200)
			err_count++;
		check("resume drive", {31'h0, dt_oe}, 32'h1);
		xfer(1'b0, IDX_RX_BUFFER, 8'h0);
		check("rx word", rdata, 32'h69);
		wait_idle();
		// software drops the enable to keep the line quiet
		xfer(1'b1, IDX_TX_STATUS, 8'h90);
		repeat (2) @(posedge pclk);
		check("quiet after", {31'h0, dt_oe}, 32'h0);
		conclude();
	end
endmodule

`default_nettype wire

// ==== usart_sync_tx.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// - half duplex: transmit and receive exclude
// - sync select bit enables synchronous operation
// - port enable assigns clock and data pins
// - clock source bit drives shift clock out
// - reload shifter only after last bit
// - buffer to shifter move sets empty flag
// - empty flag hardware only, cleared by write
// - interrupt gated by transmit interrupt enable
// - read-only shifter empty status, no interrupt
// - transmit enable, but shift only when loaded
// - drive on rising, stable at falling edge
// - baud generator held off without enables
// - write to empty shifter passes straight through
// - clearing transmit enable aborts, pins float
// - receive enable pauses transmit, data floats
// - single receive done clears enable, resumes
// - nine-bit mode, ninth bit from status
// - ninth bit sampled at shifter load
// - bit three of status registers reads zero
// - master only with clock source and sync
module usart_sync_tx
	import usart_sync_tx_pkg::*;
(
	input  wire logic                  pclk,          // bus clock
	input  wire logic                  presetn,       // async reset
	input  wire logic                  psel,          // apb select
	input  wire logic                  penable,       // apb enable
	input  wire logic                  pwrite,        // apb direction
	input  wire logic [ADDR_WIDTH-1:0] paddr,         // apb address
	input  wire logic [31:0]           pwdata,        // apb write data
	output logic      [31:0]           prdata,        // apb read data
	output logic                       pready,        // apb ready
	output logic                       pslverr,       // apb error
	output logic                       shift_clock_o, // clock line out
	output logic                       shift_clock_oe,// clock line drive
	input  wire logic                  serial_data_i, // data line in
	output logic                       serial_data_o, // data line out
	output logic                       serial_data_oe,// data line drive
	output logic                       tx_irq         // transmit request
);

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [7:0]  flags;
		logic        transmit_buffer_empty_flag;
		logic [7:0]  irq_en;
		logic        port_enable;
		logic        rx9;
		logic        single_receive_enable;
		logic        continuous_receive_enable;
		logic        clock_source_master;
		logic        tx9;
		logic        transmit_enable;
		logic        sync;
		logic        brgh;
		logic        ninth_transmit_bit;
		logic [7:0]  baud_div;
		logic [7:0]  txbuf;
		logic        buf_full;
		logic [8:0]  transmit_shifter;
		logic [3:0]  tx_left;
		logic        shifter_empty;
		logic [7:0]  baud_cnt;
		logic        sck;
		logic [8:0]  rx_sh;
		logic [3:0]  rx_left;
		logic [7:0]  rxbuf;
		logic        din_meta;
		logic        din_sync;
		logic        ck_oe;
		logic        dt_out;
		logic        dt_oe;
		logic        irq;
	} state_type;

	state_type cur;
	state_type next_state;

	////////////////////////////////////////////////////////////////////
	function automatic logic [ADDR_WIDTH-1:0] addr_of(logic [7:0] idx);
		return ADDR_WIDTH'({idx, 2'b00});
	endfunction

	function automatic logic [3:0] word_bits(logic nine);
		return nine ? BITS_LONG : BITS_SHORT;
	endfunction

	logic       hit_flags;
	logic       hit_rxs;
	logic       hit_txb;
	logic       hit_rxb;
	logic       hit_ien;
	logic       hit_txs;
	logic       hit_baud;
	logic       mapped;
	logic       commit;
	logic       wr_txb;
	logic       master;
	logic       rx_active;
	logic       tx_path;
	logic       baud_run;
	logic       tick;
	logic       rise;
	logic       fall;
	logic       load_idle;
	logic       load_b2b;
	logic [7:0] txs_read;
	logic [7:0] rxs_read;
	logic [7:0] rd_byte;

	assign hit_flags = paddr == addr_of(IDX_IRQ_FLAGS);
	assign hit_rxs   = paddr == addr_of(IDX_RX_STATUS);
	assign hit_txb   = paddr == addr_of(IDX_TX_BUFFER);
	assign hit_rxb   = paddr == addr_of(IDX_RX_BUFFER);
	assign hit_ien   = paddr == addr_of(IDX_IRQ_ENABLES);
	assign hit_txs   = paddr == addr_of(IDX_TX_STATUS);
	assign hit_baud  = paddr == addr_of(IDX_BAUD_DIV);
	assign mapped    = hit_flags | hit_rxs | hit_txb | hit_rxb | hit_ien
		| hit_txs | hit_baud;
	// writes land only on the edge that sees pready high
	assign commit    = psel & penable & cur.pready & pwrite & mapped;
	assign wr_txb    = commit & hit_txb;

	assign master    = cur.port_enable & cur.sync & cur.clock_source_master;
	assign rx_active = master & (cur.single_receive_enable | cur.continuous_receive_enable);
	assign tx_path   = master & cur.transmit_enable & ~rx_active;
	// generator runs only with an enable set
	assign baud_run  = master & (cur.transmit_enable | cur.single_receive_enable | cur.continuous_receive_enable);
	assign tick      = baud_run & (cur.baud_cnt == 8'h00)
		& (cur.sck | rx_active | (tx_path & (cur.tx_left != 4'h0)));
	assign rise      = tick & ~cur.sck;
	assign fall      = tick & cur.sck;
	// idle shifter takes the buffer at once
	assign load_idle = tx_path & cur.shifter_empty & cur.buf_full;
	// reload only after the last bit period ends
	assign load_b2b  = tx_path & fall & ~cur.shifter_empty
		& (cur.tx_left == 4'h0) & cur.buf_full;

	always_comb begin
		txs_read = {cur.clock_source_master, cur.tx9, cur.transmit_enable, cur.sync, 1'b0,
			cur.brgh, cur.shifter_empty, cur.ninth_transmit_bit};
		rxs_read = {cur.port_enable, cur.rx9, cur.single_receive_enable, cur.continuous_receive_enable,
			4'h0};
		rd_byte  = 8'h00;
		if (hit_flags) begin
			rd_byte = cur.flags;
			rd_byte[IRQ_TX_BIT] = cur.transmit_buffer_empty_flag;
		end
		if (hit_rxs)
			rd_byte = rxs_read;
		if (hit_txb)
			rd_byte = cur.txbuf;
		if (hit_rxb)
			rd_byte = cur.rxbuf;
		if (hit_ien)
			rd_byte = cur.irq_en;
		if (hit_txs)
			rd_byte = txs_read;
		if (hit_baud)
			rd_byte = cur.baud_div;
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = cur;

		// apb: one wait cycle, then registered answer
		next_state.pready = psel & penable & ~cur.pready;
		if (psel & penable & ~cur.pready) begin
			next_state.prdata  = {24'h000000, rd_byte};
			next_state.pslverr = ~mapped;
		end

		next_state.din_meta = serial_data_i;
		next_state.din_sync = cur.din_meta;

		// baud generator, half clock period is divisor plus one
		if (!baud_run) begin
			next_state.baud_cnt = 8'h00;
			next_state.sck      = 1'b0;
		end else if (cur.baud_cnt != 8'h00) begin
			next_state.baud_cnt = cur.baud_cnt - 8'h01;
		end else if (tick) begin
			next_state.baud_cnt = cur.baud_div;
			next_state.sck      = ~cur.sck;
		end

		// new bit on rising edge, lsb first
		if (tx_path & rise & (cur.tx_left != 4'h0)) begin
			next_state.dt_out  = cur.transmit_shifter[0];
			next_state.transmit_shifter     = {1'b0, cur.transmit_shifter[8:1]};
			next_state.tx_left = cur.tx_left - 4'h1;
		end
		if (tx_path & fall & (cur.tx_left == 4'h0) & ~cur.buf_full)
			next_state.shifter_empty = 1'b1;

		if (load_idle | load_b2b) begin
			next_state.transmit_shifter           = {cur.ninth_transmit_bit, cur.txbuf};
			next_state.tx_left       = word_bits(cur.tx9);
			next_state.shifter_empty = 1'b0;
			next_state.buf_full      = 1'b0;
		end

		// single receive clocks one word then ends
		if (rx_active & rise & (cur.rx_left == 4'h0))
			next_state.rx_left = word_bits(cur.rx9);
		if (rx_active & fall & (cur.rx_left != 4'h0)) begin
			next_state.rx_sh   = {cur.din_sync, cur.rx_sh[8:1]};
			next_state.rx_left = cur.rx_left - 4'h1;
			if (cur.rx_left == 4'h1) begin
				next_state.rxbuf = cur.rx9 ? cur.rx_sh[8:1]
					: {cur.din_sync, cur.rx_sh[8:2]};
				if (!cur.continuous_receive_enable)
					next_state.single_receive_enable = 1'b0;
			end
		end
		if (!rx_active)
			next_state.rx_left = 4'h0;

		// clearing the enable resets the transmitter
		if (!cur.transmit_enable) begin
			next_state.tx_left       = 4'h0;
			next_state.shifter_empty = 1'b1;
		end

		// register writes; a software set beats the hardware clear
		if (commit & hit_flags)
			next_state.flags = pwdata[7:0];
		if (commit & hit_rxs) begin
			next_state.port_enable = pwdata[RCS_PORT_ENABLE];
			next_state.rx9         = pwdata[RCS_RX9];
			next_state.single_receive_enable        = pwdata[RCS_SINGLE_RECEIVE_ENABLE];
			next_state.continuous_receive_enable        = pwdata[RCS_CONTINUOUS_RECEIVE_ENABLE];
		end
		if (commit & hit_ien)
			next_state.irq_en = pwdata[7:0];
		if (commit & hit_txs) begin
			next_state.clock_source_master = pwdata[TXS_CLOCK_SOURCE_MASTER];
			next_state.tx9  = pwdata[TXS_TX9];
			next_state.transmit_enable = pwdata[TXS_TRANSMIT_ENABLE];
			next_state.sync = pwdata[TXS_SYNC];
			next_state.brgh = pwdata[TXS_BRGH];
			next_state.ninth_transmit_bit = pwdata[TXS_NINTH_TRANSMIT_BIT];
		end
		if (commit & hit_baud)
			next_state.baud_div = pwdata[7:0];
		if (wr_txb) begin
			next_state.txbuf    = pwdata[7:0];
			next_state.buf_full = 1'b1;
		end

		// flag cleared by buffer write, set wins
		if (wr_txb)
			next_state.transmit_buffer_empty_flag = 1'b0;
		// setting the enable with the buffer empty raises the flag; a later write still clears it
		if (load_idle | load_b2b
			| (commit & hit_txs & pwdata[TXS_TRANSMIT_ENABLE] & ~cur.buf_full))
			next_state.transmit_buffer_empty_flag = 1'b1;

		next_state.irq = next_state.transmit_buffer_empty_flag & cur.irq_en[IRQ_TX_BIT];

		next_state.ck_oe = baud_run;
		next_state.dt_oe = tx_path;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur               <= '0;
			cur.flags         <= RST_IRQ_FLAGS;
			cur.irq_en        <= RST_IRQ_ENABLES;
			cur.port_enable   <= RST_RX_STATUS[RCS_PORT_ENABLE];
			cur.txbuf         <= RST_TX_BUFFER;
			cur.rxbuf         <= RST_RX_BUFFER;
			cur.baud_div      <= RST_BAUD_DIV;
			cur.shifter_empty <= RST_TX_STATUS[TXS_SHIFTER_EMPTY];
		end else begin
			cur <= next_state;
		end
	end

	assign prdata         = cur.prdata;
	assign pready         = cur.pready;
	assign pslverr        = cur.pslverr;
	assign shift_clock_o  = cur.sck;
	assign shift_clock_oe = cur.ck_oe;
	assign serial_data_o  = cur.dt_out;
	assign serial_data_oe = cur.dt_oe;
	assign tx_irq         = cur.irq;

	////////////////////////////////////////////////////////////////////
	default clocking dflt @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_HALF_DUPLEX: assert property (
		rx_active |=> !serial_data_oe)
		else $error("data line driven during receive");

	AST_LOAD_SETS_FLAG: assert property (
		(load_idle | load_b2b) && !wr_txb |=> cur.transmit_buffer_empty_flag && !cur.buf_full)
		else $error("load did not set flag or empty buffer");

	AST_FLAG_FALL: assert property (
		$fell(cur.transmit_buffer_empty_flag) |-> $past(wr_txb))
		else $error("flag cleared without buffer write");

	AST_IRQ_GATE: assert property (
		tx_irq |-> $past(cur.irq_en[IRQ_TX_BIT]) && cur.transmit_buffer_empty_flag)
		else $error("request without enable or flag");

	AST_EMPTY_IDLE: assert property (
		cur.shifter_empty |-> cur.tx_left == 4'h0)
		else $error("shifter empty with bits pending");

	AST_FALL_STABLE: assert property (
		fall |=> $stable(serial_data_o))
		else $error("data changed at falling edge");

	AST_BAUD_HELD: assert property (
		!(cur.transmit_enable | cur.single_receive_enable | cur.continuous_receive_enable) |=>
			cur.baud_cnt == 8'h00 && !shift_clock_o)
		else $error("baud generator not held");

	AST_STRAIGHT: assert property (
		(wr_txb && tx_path && cur.shifter_empty && !cur.buf_full)
			|=> cur.buf_full ##1 !cur.buf_full && !cur.shifter_empty)
		else $error("write did not pass into shifter");

	AST_ABORT: assert property (
		$fell(cur.transmit_enable) |=> !serial_data_oe && cur.shifter_empty)
		else $error("abort did not float data line");

	AST_BIT3_ZERO: assert property (
		(psel && penable && !pready && (hit_txs || hit_rxs))
			|=> !prdata[3])
		else $error("reserved bit reads one");

	COV_B2B: cover property (load_b2b);
	COV_RX_PAUSE: cover property (tx_path ##1 rx_active);
	COV_ABORT: cover property (!cur.shifter_empty ##1 !cur.transmit_enable);
	COV_SINGLE_DONE: cover property ($fell(cur.single_receive_enable) && cur.transmit_enable);

endmodule

`default_nettype wire

// ==== usart_sync_tx_pkg.sv ====
package usart_sync_tx_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_IRQ_FLAGS   = 8'h0c;
	localparam logic [7:0]  IDX_RX_STATUS   = 8'h18;
	localparam logic [7:0]  IDX_TX_BUFFER   = 8'h19;
	localparam logic [7:0]  IDX_RX_BUFFER   = 8'h1a;
	localparam logic [7:0]  IDX_IRQ_ENABLES = 8'h8c;
	localparam logic [7:0]  IDX_TX_STATUS   = 8'h98;
	localparam logic [7:0]  IDX_BAUD_DIV    = 8'h99;
	localparam int          ADDR_WIDTH      = 12;

	// transmit_status_control fields
	localparam int          TXS_CLOCK_SOURCE_MASTER   = 7;
	localparam int          TXS_TX9    = 6;
	localparam int          TXS_TRANSMIT_ENABLE   = 5;
	localparam int          TXS_SYNC   = 4;
	localparam int          TXS_RSVD   = 3;
	localparam int          TXS_BRGH   = 2;
	localparam int          TXS_SHIFTER_EMPTY   = 1;
	localparam int          TXS_NINTH_TRANSMIT_BIT   = 0;
	// receive_status_control fields
	localparam int          RCS_PORT_ENABLE   = 7;
	localparam int          RCS_RX9    = 6;
	localparam int          RCS_SINGLE_RECEIVE_ENABLE   = 5;
	localparam int          RCS_CONTINUOUS_RECEIVE_ENABLE   = 4;
	localparam int          RCS_RSVD   = 3;
	// flag and enable position of the transmit event
	localparam int          IRQ_TX_BIT = 4;

	// reset values
	localparam logic [7:0]  RST_IRQ_FLAGS   = 8'h00;
	localparam logic [7:0]  RST_RX_STATUS   = 8'h00;
	localparam logic [7:0]  RST_TX_BUFFER   = 8'h00;
	localparam logic [7:0]  RST_RX_BUFFER   = 8'h00;
	localparam logic [7:0]  RST_IRQ_ENABLES = 8'h00;
	localparam logic [7:0]  RST_TX_STATUS   = 8'h02;
	localparam logic [7:0]  RST_BAUD_DIV    = 8'h00;

	// word lengths in bits
	localparam logic [3:0]  BITS_SHORT = 4'h8;
	localparam logic [3:0]  BITS_LONG  = 4'h9;

	// buffer to shifter move takes one instruction cycle
	localparam int          TRANSFER_CYCLES = 1;

endpackage
